/* File: include/rfd_map.svh */
// Frame codes, byte positions and sizes used by the calibration file download responder.
`ifndef RFD_MAP_SVH
`define RFD_MAP_SVH
`define RFD_CODE_CMD 8'h07
`define RFD_CODE_ACK 8'h06
`define RFD_CODE_NAK 8'h15
`define RFD_ADDR_BCAST 8'hff
`define RFD_CMD0_FILE 8'h44
`define RFD_CMD1_ANALOG 8'h4c
`define RFD_CMD1_DIGITAL 8'h32
`define RFD_CMD2_SIZE 8'h3f
`define RFD_CMD2_FETCH 8'h4e
`define RFD_SUM_OK 8'hff
`define RFD_B_CODE 3'h0
`define RFD_B_ADDR 3'h1
`define RFD_B_CMD0 3'h2
`define RFD_B_CMD1 3'h3
`define RFD_B_CMD2 3'h4
`define RFD_B_LEN 3'h5
`define RFD_B_HCHK 7'h06
`define RFD_B_DATA 7'h07
`define RFD_MAX_LEN 8'h4a
`define RFD_PKT_BYTES 30
`define RFD_FILE_BYTES 256
`define RFD_SIZE_LEN 8'h01
`define RFD_FETCH_LEN 8'h01
`endif

/* File: include/rfd_pkg.sv */
// Types shared by the calibration file download responder.
package rfd_pkg;
  // Gray-coded along receive, evaluate, transmit.
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_EVAL = 2'b01,
    ST_TX = 2'b11
  } rfd_state_e;
endpackage

/* File: logic/rfd_responder.sv */
// Serial command responder that serves the analog and digital calibration files.
// Behaviour
// R1: Size query answers one-byte packet count.
// R2: Host fetch request carries one index byte.
// R3: Fetch returns packet content, 30 bytes max.
// R4: Host asks count first, stays in range.
// R5: Ack echoes address and command, checksummed.
// R6: Host fetch frame is nine bytes long.
// R7: Analog and digital files served separately.
// R8: Header bytes zero to six sum 0xFF.
// R9: Data checksum inverts data sum, data only.
// R10: Ack on success, negative ack on failure.
// R11: Accept broadcast or own unit address.
// R12: Negative ack on bad index or checksum.
`timescale 1ns/1ps
`default_nettype none
`include "rfd_map.svh"
module rfd_responder #(
  parameter int PKT_BYTES = `RFD_PKT_BYTES,
  parameter int FILE_BYTES = `RFD_FILE_BYTES,
  localparam int AW = $clog2(FILE_BYTES),
  localparam int LW = $clog2(FILE_BYTES + 1)
) (
  input wire logic clk_in, // 40 MHz clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic [3:0] unit_addr_in, // Configured unit address.
  input wire logic rx_valid_in, // Received byte strobe.
  input wire logic [7:0] rx_data_in, // Received byte.
  input wire logic tx_ready_in, // Transmitter takes the byte.
  output logic tx_valid_out, // Byte to send is present.
  output logic [7:0] tx_data_out, // Byte to send.
  input wire logic load_valid_in, // File byte write strobe.
  input wire logic load_file_in, // 0 analog, 1 digital.
  input wire logic [AW-1:0] load_addr_in, // File byte address.
  input wire logic [7:0] load_data_in, // File byte value.
  input wire logic [LW-1:0] analog_len_in, // Analog file length in bytes.
  input wire logic [LW-1:0] digital_len_in // Digital file length in bytes.
);

  // A larger file would need packet indices beyond one byte.
  if (PKT_BYTES < 1 || PKT_BYTES > int'(`RFD_MAX_LEN) || FILE_BYTES < 2
      || FILE_BYTES > 255 * PKT_BYTES) begin : g_bad_size
    $error("rfd_responder: unsupported packet or file size");
  end

  ////////////////////////////////////////////////////////////////////////////
  // File store, written by the loader port.
  logic [7:0] mem [2][FILE_BYTES];

  // Plain write port; reads happen during transmission only.
  always_ff @(posedge clk_in) begin
    if (load_valid_in) begin
      mem[load_file_in][load_addr_in] <= load_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state.
  rfd_pkg::rfd_state_e st, next_st;
  logic [7:0] hdr [7];
  logic [7:0] next_hdr [7];
  logic [6:0] icnt, next_icnt, ocnt, next_ocnt;
  logic [7:0] rsum, next_rsum, dsum, next_dsum, dchk, next_dchk, rdata0, next_rdata0;
  logic [7:0] tsum, next_tsum, osum, next_osum, rlen, next_rlen, pcnt, next_pcnt;
  logic [15:0] rbase, next_rbase;
  logic ack, next_ack, rfile, next_rfile, next_tx_valid;
  logic [7:0] next_tx_data;

  // Decode helpers, valid while evaluating.
  logic addr_ok, hdr_ok, dat_ok, is_file, size_q, fetch_q;
  logic [LW-1:0] flen;
  logic [15:0] remain, base;
  logic [7:0] pcount, obyte;
  logic [6:0] total;
  logic [AW-1:0] raddr;

  // Packet count rounds up: a short last packet still counts.
  always_comb begin
    flen = (hdr[`RFD_B_CMD1] == `RFD_CMD1_DIGITAL) ? digital_len_in : analog_len_in;
    pcount = 8'((16'(flen) + 16'(PKT_BYTES - 1)) / 16'(PKT_BYTES));
    base = 16'(rdata0) * 16'(PKT_BYTES);
    remain = 16'(flen) - base;
    // R11: address filter
    addr_ok = (hdr[`RFD_B_ADDR] == `RFD_ADDR_BCAST) || (hdr[`RFD_B_ADDR] == {4'h0, unit_addr_in});
    // R8: header checksum check
    hdr_ok = (rsum == `RFD_SUM_OK);
    // R9: data checksum check
    dat_ok = (hdr[`RFD_B_LEN] == 8'h00) || (8'(dsum + dchk) == `RFD_SUM_OK);
    // R7: per-file command pairs
    is_file = (hdr[`RFD_B_CMD0] == `RFD_CMD0_FILE)
      && (hdr[`RFD_B_CMD1] == `RFD_CMD1_ANALOG || hdr[`RFD_B_CMD1] == `RFD_CMD1_DIGITAL);
    size_q = (hdr[`RFD_B_CMD2] == `RFD_CMD2_SIZE) && (hdr[`RFD_B_LEN] == 8'h00);
    // R12: index range check
    fetch_q = (hdr[`RFD_B_CMD2] == `RFD_CMD2_FETCH) && (hdr[`RFD_B_LEN] == `RFD_FETCH_LEN)
      && (rdata0 < pcount);
  end

  // Outgoing byte for the next slot; checksum bytes invert the running sums.
  always_comb begin
    total = (rlen == 8'h00) ? 7'(`RFD_B_HCHK + 7'h01) : 7'(`RFD_B_DATA + 7'(rlen) + 7'h01);
    raddr = AW'(rbase + 16'(ocnt - `RFD_B_DATA));
    if (ocnt == 7'h00) begin
      // R10: ack or negative ack code
      obyte = ack ? `RFD_CODE_ACK : `RFD_CODE_NAK;
    end else if (ocnt < 7'(`RFD_B_LEN)) begin
      // R5: echo address and command
      obyte = hdr[ocnt[2:0]];
    end else if (ocnt == 7'(`RFD_B_LEN)) begin
      obyte = rlen;
    end else if (ocnt == `RFD_B_HCHK) begin
      // R8: header checksum out
      obyte = ~tsum;
    end else if (ocnt == total - 7'h01) begin
      // R9: data checksum out
      obyte = ~osum;
    end else if (hdr[`RFD_B_CMD2] == `RFD_CMD2_SIZE) begin
      // R1: packet count byte, a count of zero included
      obyte = pcnt;
    end else begin
      // R3: packet content
      obyte = mem[rfile][raddr];
    end
  end

  // Next-state logic for receive, evaluate and transmit.
  always_comb begin
    next_st = st;
    next_hdr = hdr;
    next_icnt = icnt;
    next_ocnt = ocnt;
    next_rsum = rsum;
    next_dsum = dsum;
    next_dchk = dchk;
    next_rdata0 = rdata0;
    next_tsum = tsum;
    next_osum = osum;
    next_rlen = rlen;
    next_pcnt = pcnt;
    next_rbase = rbase;
    next_ack = ack;
    next_rfile = rfile;
    next_tx_valid = tx_valid_out;
    next_tx_data = tx_data_out;
    case (st)
      rfd_pkg::ST_RX: begin
        // A stray byte outside a frame is dropped until a command code shows up.
        if (rx_valid_in && !(icnt == 7'h00 && rx_data_in != `RFD_CODE_CMD)) begin
          next_icnt = icnt + 7'h01;
          if (icnt <= `RFD_B_HCHK) begin
            next_hdr[icnt[2:0]] = rx_data_in;
            next_rsum = (icnt == 7'h00) ? rx_data_in : 8'(rsum + rx_data_in);
            next_dsum = 8'h00;
          end else if (icnt < `RFD_B_DATA + 7'(hdr[`RFD_B_LEN])) begin
            next_dsum = 8'(dsum + rx_data_in);
          end
          if (icnt == `RFD_B_DATA) begin
            next_rdata0 = rx_data_in;
          end
          if (icnt == 7'(`RFD_B_LEN) && rx_data_in > `RFD_MAX_LEN) begin
            next_icnt = 7'h00;
          end else if ((icnt == `RFD_B_HCHK && hdr[`RFD_B_LEN] == 8'h00)
              || (icnt > `RFD_B_HCHK && icnt == `RFD_B_DATA + 7'(hdr[`RFD_B_LEN]))) begin
            next_dchk = rx_data_in;
            next_st = rfd_pkg::ST_EVAL;
          end
        end
      end
      rfd_pkg::ST_EVAL: begin
        next_icnt = 7'h00;
        next_ocnt = 7'h00;
        next_tsum = 8'h00;
        next_osum = 8'h00;
        next_rfile = (hdr[`RFD_B_CMD1] == `RFD_CMD1_DIGITAL);
        next_rbase = base;
        // R12: negative ack on a checksum, command, length or index failure
        next_ack = hdr_ok && dat_ok && is_file && (size_q || fetch_q);
        next_pcnt = (next_ack && size_q) ? pcount : 8'h00;
        if (!next_ack) begin
          next_rlen = 8'h00;
        end else if (size_q) begin
          next_rlen = `RFD_SIZE_LEN;
        end else begin
          // R3: short final packet
          next_rlen = (remain < 16'(PKT_BYTES)) ? remain[7:0] : 8'(PKT_BYTES);
        end
        // R11: silent for other units
        next_st = addr_ok ? rfd_pkg::ST_TX : rfd_pkg::ST_RX;
      end
      rfd_pkg::ST_TX: begin
        if (!tx_valid_out || tx_ready_in) begin
          if (ocnt == total) begin
            next_tx_valid = 1'b0;
            next_st = rfd_pkg::ST_RX;
          end else begin
            next_tx_valid = 1'b1;
            next_tx_data = obyte;
            next_ocnt = ocnt + 7'h01;
            if (ocnt < `RFD_B_HCHK) begin
              next_tsum = 8'(tsum + obyte);
            end else if (ocnt > `RFD_B_HCHK && ocnt < total - 7'h01) begin
              next_osum = 8'(osum + obyte);
            end
          end
        end
      end
      default: begin
        next_st = rfd_pkg::ST_RX;
      end
    endcase
  end

  // Registers only; reset puts the responder back to hunting for a frame.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= rfd_pkg::ST_RX;
      hdr <= '{default: 8'h00};
      icnt <= 7'h00;
      ocnt <= 7'h00;
      rsum <= 8'h00;
      dsum <= 8'h00;
      dchk <= 8'h00;
      rdata0 <= 8'h00;
      tsum <= 8'h00;
      osum <= 8'h00;
      rlen <= 8'h00;
      pcnt <= 8'h00;
      rbase <= 16'h0000;
      ack <= 1'b0;
      rfile <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
    end else begin
      st <= next_st;
      hdr <= next_hdr;
      icnt <= next_icnt;
      ocnt <= next_ocnt;
      rsum <= next_rsum;
      dsum <= next_dsum;
      dchk <= next_dchk;
      rdata0 <= next_rdata0;
      tsum <= next_tsum;
      osum <= next_osum;
      rlen <= next_rlen;
      pcnt <= next_pcnt;
      rbase <= next_rbase;
      ack <= next_ack;
      rfile <= next_rfile;
      tx_valid_out <= next_tx_valid;
      tx_data_out <= next_tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. During a handshake of byte k, ocnt already reads k+1.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic hs;
  logic [7:0] asum;
  assign hs = tx_valid_out && tx_ready_in;

  // Independent sum of header bytes as they leave, restarted at the first data byte.
  always_ff @(posedge clk_in) begin
    if (hs) begin
      asum <= (ocnt == 7'h01 || ocnt == 7'h08) ? tx_data_out : 8'(asum + tx_data_out);
    end
  end

  a_first_code: assert property (hs && ocnt == 7'h01 |-> // R10
    tx_data_out == (ack ? `RFD_CODE_ACK : `RFD_CODE_NAK)) else $error("bad frame code");
  a_hdr_sum: assert property (hs && ocnt == 7'h07 |-> // R8
    8'(asum + tx_data_out) == `RFD_SUM_OK) else $error("header sum wrong");
  a_data_sum: assert property (hs && ocnt == total && rlen != 8'h00 |-> // R9
    8'(asum + tx_data_out) == `RFD_SUM_OK) else $error("data sum wrong");
  a_echo_cmd: assert property (hs && ocnt == 7'h03 |-> // R5
    tx_data_out == hdr[`RFD_B_CMD0]) else $error("command not echoed");
  a_size_len: assert property (st == rfd_pkg::ST_EVAL && size_q && hdr_ok && is_file |=> // R1
    rlen == `RFD_SIZE_LEN) else $error("size reply length wrong");
  a_pkt_max: assert property (st == rfd_pkg::ST_TX |-> // R3
    rlen <= 8'(PKT_BYTES)) else $error("packet too long");
  a_nak_empty: assert property (st == rfd_pkg::ST_TX && !ack |-> // R12
    rlen == 8'h00) else $error("nak carries data");
  a_other_unit: assert property (st == rfd_pkg::ST_EVAL && !addr_ok |=> // R11
    st == rfd_pkg::ST_RX && !tx_valid_out) else $error("answered foreign frame");
  a_file_pick: assert property (st == rfd_pkg::ST_EVAL |=> // R7
    rfile == ($past(hdr[`RFD_B_CMD1]) == `RFD_CMD1_DIGITAL)) else $error("wrong file");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> // R5
    tx_valid_out && $stable(tx_data_out)) else $error("byte dropped");

  c_size_ack: cover property (st == rfd_pkg::ST_TX && ack && pcnt != 8'h00);
  c_fetch_ack: cover property (st == rfd_pkg::ST_TX && ack && hdr[`RFD_B_CMD2] == `RFD_CMD2_FETCH
    && rfile);
  c_nak_sent: cover property (hs && ocnt == 7'h01 && tx_data_out == `RFD_CODE_NAK);

endmodule // rfd_responder
`default_nettype wire

/* File: verification/rfd_host_model.sv */
// Host model that sends request frames and gathers the reply bytes.
`timescale 1ns/1ps
`default_nettype none
module rfd_host_model (
  input wire logic clk_in, // 40 MHz clock.
  input wire logic tx_valid_in, // Reply byte present.
  input wire logic [7:0] tx_data_in, // Reply byte.
  output logic tx_ready_out, // Reply byte taken.
  output logic rx_valid_out, // Request byte strobe.
  output logic [7:0] rx_data_out // Request byte.
);
  int seed = 69684;
  logic [7:0] rsp[$];
  initial begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Random stalls make the responder hold each byte until taken.
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) rsp.push_back(tx_data_in);
    tx_ready_out <= ($random(seed) & 32'sd1) != 0;
  end
  // Sends one whole frame back to back, then waits until the line is quiet.
  task automatic exchange(input logic [7:0] req[$], output logic [7:0] got[$]);
    int idle;
    idle = 0;
    rsp.delete();
    foreach (req[i]) begin
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= req[i];
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out; // Released bytes do not keep the last value.
    for (int k = 0; k < 400 && idle < 20; k++) begin
      @(posedge clk_in);
      idle = tx_valid_in ? 0 : idle + 1;
    end
    got = rsp;
  endtask
endmodule // rfd_host_model
`default_nettype wire

/* File: verification/rfd_responder_test.sv */
// Self-checking bench for the calibration file download responder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module rfd_responder_test;
  typedef logic [7:0] rfd_q_t[$];
  logic clk_in = 1'b0, rst_n_in = 1'b0, rx_valid_in, tx_ready_in, tx_valid_out;
  logic load_valid_in = 1'b0, load_file_in = 1'b0;
  logic [3:0] unit_addr_in = 4'h5;
  logic [7:0] rx_data_in, tx_data_out, load_addr_in = 8'h00, load_data_in = 8'h00;
  logic [8:0] flen[2] = '{9'h041, 9'h01e};
  logic [7:0] fm[2][256];
  rfd_q_t got, e, d, r;
  int fail_count = 0, n_compared = 0;
  rfd_responder i_rfd_responder (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .unit_addr_in(unit_addr_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .load_valid_in(load_valid_in), .load_file_in(load_file_in),
    .load_addr_in(load_addr_in), .load_data_in(load_data_in),
    .analog_len_in(flen[0]), .digital_len_in(flen[1]));
  rfd_host_model i_rfd_host_model (.clk_in(clk_in), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in));
  always #12.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  // frame with header checksum, plus data checksum when data is present.
  function automatic rfd_q_t mk(logic [7:0] code, a, c1, c2, rfd_q_t dat);
    logic [7:0] s;
    rfd_q_t f;
    f = '{code, a, 8'h44, c1, c2, 8'(dat.size())};
    s = 8'h00;
    foreach (f[i]) s += f[i];
    f.push_back(8'hff - s);
    s = 8'h00;
    foreach (dat[i]) begin
      f.push_back(dat[i]);
      s += dat[i];
    end
    if (dat.size() > 0) f.push_back(8'hff - s);
    return f;
  endfunction
  // One request, then the whole reply is compared byte by byte.
  task automatic xfer(rfd_q_t req, rfd_q_t exp);
    i_rfd_host_model.exchange(req, got);
    `CHK(got.size(), exp.size())
    foreach (exp[i]) `CHK(got[i], exp[i])
    $display("exchange done, %0d bytes", exp.size());
  endtask
  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence: load both files, then query and fetch each of them.
  initial begin
    logic [7:0] c1, a;
    int cnt;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // The unit address is drawn so the address filter sees more than one value.
    unit_addr_in <= 4'($random(i_rfd_host_model.seed));
    for (int i = 0; i < 512; i++) begin
      @(posedge clk_in);
      fm[i / 256][i % 256] = 8'($random(i_rfd_host_model.seed));
      load_valid_in <= 1'b1;
      load_file_in <= i[8];
      load_addr_in <= i[7:0];
      load_data_in <= fm[i / 256][i % 256];
    end
    @(posedge clk_in);
    load_valid_in <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      c1 = f ? 8'h32 : 8'h4c;
      cnt = (int'(flen[f]) + 29) / 30;
      a = $random(i_rfd_host_model.seed) & 1 ? 8'hff : {4'h0, unit_addr_in};
      xfer(mk(8'h07, a, c1, 8'h3f, e), mk(8'h06, a, c1, 8'h3f, '{8'(cnt)}));
      for (int p = 0; p <= cnt; p++) begin
        d = {};
        for (int b = 30 * p; b < flen[f] && b < 30 * p + 30; b++) d.push_back(fm[f][b]);
        r = mk(8'h07, a, c1, 8'h4e, '{8'(p)});
        if (p < cnt) xfer(r, mk(8'h06, a, c1, 8'h4e, d));
        else xfer(r, mk(8'h15, a, c1, 8'h4e, e));
      end
    end
    // Corner cases: foreign address, broken checksums, wrong length.
    xfer(mk(8'h07, {4'h0, ~unit_addr_in}, 8'h32, 8'h3f, e), e);
    r = mk(8'h07, 8'hff, 8'h4c, 8'h4e, '{8'h00});
    r[6] ^= 8'h01;
    xfer(r, mk(8'h15, 8'hff, 8'h4c, 8'h4e, e));
    r[6] ^= 8'h01;
    r[8] ^= 8'h10;
    xfer(r, mk(8'h15, 8'hff, 8'h4c, 8'h4e, e));
    a = {4'h0, unit_addr_in};
    xfer(mk(8'h07, a, 8'h32, 8'h3f, '{8'h00}), mk(8'h15, a, 8'h32, 8'h3f, e));
    summarize();
  end
  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule // rfd_responder_test
`default_nettype wire
